// ==== logic/lsbe_pkg.sv ====
`default_nettype none

// Shared widths, constants and carriers of the shift, bit and branch
// execution datapath.
package lsbe_pkg;

   // Datapath and operand widths.
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int LIT_W = 9;
   localparam int PC_W = 15;
   localparam int FILE_DEPTH = 128;

   // Bit positions inside a data byte.
   localparam int LSB_POS = 0;
   localparam int MSB_POS = 7;

   // Destination select encodings for two-operand register instructions.
   localparam logic DEST_ACCUM = 1'h0;
   localparam logic DEST_FILE = 1'h1;

   // Reset values.
   localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

   // Program counter steps.
   localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
   localparam logic [PC_W-1:0] PC_SKIP_STEP = 15'h0002;

   // Instruction kinds handled by this datapath, one-hot.
   typedef enum logic [7:0] {
      OP_AND_LIT  = 8'h01,
      OP_AND_FILE = 8'h02,
      OP_ASR      = 8'h04,
      OP_BIT_CLR  = 8'h08,
      OP_BIT_SET  = 8'h10,
      OP_REL_JMP  = 8'h20,
      OP_ACC_JMP  = 8'h40,
      OP_TEST_SKP = 8'h80
   } lsbe_op_t;

   // Sequencer states, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_EXEC = 3'h2,
      ST_NOP  = 3'h4
   } lsbe_state_t;

   // One decoded instruction as issued by the core.
   typedef struct packed {
      lsbe_op_t op;
      logic [LIT_W-1:0] lit;
      logic [ADDR_W-1:0] fileAddr;
      logic [BIT_W-1:0] bitIdx;
      logic destSel;
   } lsbe_instr_t;

   // Status flags kept by this datapath.
   typedef struct packed {
      logic carry;
      logic zero;
   } lsbe_flags_t;

   localparam lsbe_flags_t FLAGS_RST = 2'h0;

endpackage : lsbe_pkg

`default_nettype wire

// ==== logic/lsbe_file_mem.sv ====
`default_nettype none

// Data register file: one write port and one read port whose data
// come out of a register, so a read shows one cycle after its address.
module lsbe_file_mem
   import lsbe_pkg::*;
(
   input wire logic clk_sys, // System clock.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic wrEn, // Write strobe.
   input wire logic [lsbe_pkg::ADDR_W-1:0] wrAddr, // Write address.
   input wire logic [lsbe_pkg::DATA_W-1:0] wrData, // Write data.
   input wire logic [lsbe_pkg::ADDR_W-1:0] rdAddr, // Read address.
   output logic [lsbe_pkg::DATA_W-1:0] rdData_q // Registered read data.
);
   import lsbe_pkg::*;

   logic [DATA_W-1:0] mem [FILE_DEPTH];

   // The array itself has no reset, which keeps it a plain RAM.
   always_ff @(posedge clk_sys)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
   end

   // Read before write: a same-cycle write to rdAddr is seen next time.
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         rdData_q <= ZERO_BYTE;
      end
      else
      begin
         rdData_q <= mem[rdAddr];
      end
   end

endmodule : lsbe_file_mem

`default_nettype wire

// ==== logic/lsbe_exec.sv ====
`default_nettype none

// Summary of operation
// [RULE1] AND-literal: accumulator AND 8-bit literal into accumulator, zero only.
// [RULE2] AND-register: accumulator AND addressed register, zero flag only.
// [RULE3] Destination select 0 writes accumulator, 1 writes the register.
// [RULE4] Arithmetic right shift moves bits toward bit 0, old bit 0 to carry.
// [RULE5] Shift keeps bit 7; updates carry and zero only.
// [RULE6] Bit clear zeroes the indexed bit; other bits and flags unchanged.
// [RULE7] Bit set forces the indexed bit to one; nothing else changes.
// [RULE8] Literal branch adds signed 9-bit offset to incremented counter.
// [RULE9] Accumulator branch adds unsigned accumulator to incremented counter.
// [RULE10] Both branches take two cycles and touch no flag.
// [RULE11] Skip test with bit one lets the next instruction run.
// [RULE12] Skip test with bit zero discards next, two cycles, no flags.
// [RULE13] Counter change or true test makes the second cycle a no-op.
// [RULE14] Zero flag set when an affecting result is zero, else cleared.
// [RULE15] Instructions not affecting a flag leave carry and zero alone.
module lsbe_exec
   import lsbe_pkg::*;
(
   input wire logic clk_sys, // System clock, 25 MHz.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic opValid, // An instruction is offered.
   input wire lsbe_pkg::lsbe_instr_t opIn, // The offered instruction.
   output logic opReady, // Datapath can take an instruction.
   output logic instrDone, // Last cycle of the current instruction.
   output logic nopCycle, // The second cycle runs as a no-op.
   output logic discardNext, // A skip drops the fetched instruction.
   input wire logic accLoadEn, // Core loads the accumulator.
   input wire logic [lsbe_pkg::DATA_W-1:0] accLoadData, // Load value.
   input wire logic extWrEn, // Core writes a data register.
   input wire logic [lsbe_pkg::ADDR_W-1:0] extAddr, // Core register address.
   input wire logic [lsbe_pkg::DATA_W-1:0] extWrData, // Core write data.
   output logic [lsbe_pkg::DATA_W-1:0] fileRdData, // Registered read data.
   output logic [lsbe_pkg::DATA_W-1:0] accum_q, // Accumulator.
   output logic [lsbe_pkg::PC_W-1:0] pc_q, // Program counter.
   output lsbe_pkg::lsbe_flags_t flags_q // Carry and zero flags.
);
   import lsbe_pkg::*;

   // One-hot mask of a single bit inside a data byte.
   function automatic logic [DATA_W-1:0] bit_mask(
      input logic [BIT_W-1:0] idx
   );
      logic [DATA_W-1:0] m;
      m = ZERO_BYTE;
      m[idx] = 1'b1;
      return m;
   endfunction : bit_mask

   lsbe_state_t state_q;
   lsbe_state_t state_d;
   lsbe_instr_t instr_q;
   lsbe_instr_t instr_d;
   logic [DATA_W-1:0] accum_d;
   logic [PC_W-1:0] pc_d;
   lsbe_flags_t flags_d;

   wire logic stIdle;
   wire logic stExec;
   wire logic stNop;
   wire logic accept;
   wire logic [DATA_W-1:0] srcFile;
   wire logic [DATA_W-1:0] mask;
   wire logic [DATA_W-1:0] andOperand;
   wire logic [DATA_W-1:0] andRes;
   wire logic [DATA_W-1:0] asrRes;
   wire logic [DATA_W-1:0] clrRes;
   wire logic [DATA_W-1:0] setRes;
   wire logic [DATA_W-1:0] result;
   wire logic testedBit;
   wire logic isAndLit;
   wire logic isAndFile;
   wire logic isAsr;
   wire logic isClr;
   wire logic isSet;
   wire logic isRel;
   wire logic isAcc;
   wire logic isSkip;
   wire logic twoOperand;
   wire logic toFile;
   wire logic toAccum;
   wire logic skipTaken;
   wire logic twoCycle;
   wire logic zeroUpd;
   wire logic carryUpd;
   wire logic execWr;
   wire logic memWe;
   wire logic [ADDR_W-1:0] memWrAddr;
   wire logic [DATA_W-1:0] memWrData;
   wire logic [ADDR_W-1:0] memRdAddr;
   wire logic [PC_W-1:0] pcInc;
   wire logic [PC_W-1:0] relOffset;
   wire logic [PC_W-1:0] accOffset;

   // State decode and the issue handshake.
   assign stIdle = (state_q == ST_IDLE);
   assign stExec = (state_q == ST_EXEC);
   assign stNop = (state_q == ST_NOP);
   assign opReady = stIdle;
   assign accept = stIdle && opValid;

   // Instruction kind decode of the latched instruction.
   assign isAndLit = (instr_q.op == OP_AND_LIT);
   assign isAndFile = (instr_q.op == OP_AND_FILE);
   assign isAsr = (instr_q.op == OP_ASR);
   assign isClr = (instr_q.op == OP_BIT_CLR);
   assign isSet = (instr_q.op == OP_BIT_SET);
   assign isRel = (instr_q.op == OP_REL_JMP);
   assign isAcc = (instr_q.op == OP_ACC_JMP);
   assign isSkip = (instr_q.op == OP_TEST_SKP);

   // The register operand was read in the issue cycle and is ready now.
   assign srcFile = fileRdData;
   assign mask = bit_mask(instr_q.bitIdx);

   // [RULE1] literal AND operand
   // [RULE2] register AND operand
   assign andOperand = isAndLit ? instr_q.lit[DATA_W-1:0] : srcFile;
   assign andRes = accum_q & andOperand;

   // [RULE4] shift toward bit zero
   // [RULE5] sign bit kept
   assign asrRes = {srcFile[MSB_POS], srcFile[MSB_POS:LSB_POS+1]};

   // [RULE6] indexed bit cleared
   assign clrRes = srcFile & ~mask;

   // [RULE7] indexed bit set
   assign setRes = srcFile | mask;

   // Result selection among the data-producing instructions.
   assign result = isAsr ? asrRes :
                   isClr ? clrRes :
                   isSet ? setRes :
                   andRes;

   // [RULE3] destination select routing
   assign twoOperand = isAndFile || isAsr;
   assign toFile = (twoOperand && (instr_q.destSel == DEST_FILE))
                   || isClr || isSet;
   assign toAccum = isAndLit
                    || (twoOperand && (instr_q.destSel == DEST_ACCUM));

   // [RULE11] bit one runs the next
   // [RULE12] bit zero skips the next
   assign testedBit = |(srcFile & mask);
   assign skipTaken = isSkip && !testedBit;

   // [RULE10] branches take two cycles
   // [RULE13] second cycle is a no-op
   assign twoCycle = isRel || isAcc || skipTaken;

   // [RULE15] only listed flags move
   assign zeroUpd = isAndLit || isAndFile || isAsr;
   assign carryUpd = isAsr;

   // Register file port: execution writes win over core writes.
   assign execWr = stExec && toFile;
   assign memWe = execWr || (extWrEn && !stExec);
   assign memWrAddr = execWr ? instr_q.fileAddr : extAddr;
   assign memWrData = execWr ? result : extWrData;
   assign memRdAddr = accept ? opIn.fileAddr :
                      stIdle ? extAddr :
                      instr_q.fileAddr;

   // Branch targets, all relative to the already incremented counter.
   assign pcInc = pc_q + PC_STEP;
   // [RULE8] signed 9-bit offset
   assign relOffset = {{(PC_W-LIT_W){instr_q.lit[LIT_W-1]}}, instr_q.lit};
   // [RULE9] unsigned accumulator offset
   assign accOffset = {{(PC_W-DATA_W){1'b0}}, accum_q};

   // Completion and no-op cycle indications.
   assign instrDone = (stExec && !twoCycle) || stNop;
   assign nopCycle = stNop;
   assign discardNext = stNop && isSkip;

   // Sequencer: one execute cycle, plus a no-op cycle when needed.
   always_comb
   begin
      state_d = state_q;
      instr_d = instr_q;
      case (state_q)
         ST_IDLE:
         begin
            if (opValid)
            begin
               instr_d = opIn;
               state_d = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            // [RULE13] extra no-op cycle
            if (twoCycle)
            begin
               state_d = ST_NOP;
            end
            else
            begin
               state_d = ST_IDLE;
            end
         end
         ST_NOP:
         begin
            state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Accumulator, flags and counter updates of the execute cycle.
   always_comb
   begin
      accum_d = accum_q;
      flags_d = flags_q;
      pc_d = pc_q;
      if (stIdle && !opValid && accLoadEn)
      begin
         accum_d = accLoadData;
      end
      if (stExec)
      begin
         // [RULE3] accumulator destination
         if (toAccum)
         begin
            accum_d = result;
         end
         // [RULE14] zero flag from result
         if (zeroUpd)
         begin
            flags_d.zero = (result == ZERO_BYTE);
         end
         // [RULE4] old bit zero to carry
         if (carryUpd)
         begin
            flags_d.carry = srcFile[LSB_POS];
         end
         // [RULE8] literal branch target
         if (isRel)
         begin
            pc_d = pcInc + relOffset;
         end
         // [RULE9] accumulator branch target
         else if (isAcc)
         begin
            pc_d = pcInc + accOffset;
         end
         // [RULE12] skip over fetched instruction
         else if (skipTaken)
         begin
            pc_d = pc_q + PC_SKIP_STEP;
         end
         else
         begin
            pc_d = pcInc;
         end
      end
   end

   // State and latched instruction.
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         state_q <= ST_IDLE;
         instr_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         instr_q <= instr_d;
      end
   end

   // Architectural state held by this datapath.
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         accum_q <= ACCUM_RST;
         pc_q <= PC_RST;
         flags_q <= FLAGS_RST;
      end
      else
      begin
         accum_q <= accum_d;
         pc_q <= pc_d;
         flags_q <= flags_d;
      end
   end

   // Data register file; its registered read gives the operand timing.
   lsbe_file_mem u_file_mem (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .wrEn(memWe),
      .wrAddr(memWrAddr),
      .wrData(memWrData),
      .rdAddr(memRdAddr),
      .rdData_q(fileRdData)
   );

endmodule : lsbe_exec

`default_nettype wire

// ==== testbench/lsbe_exec_chk.sv ====
`default_nettype none

// Watches the datapath ports for cycle counts and results.
module lsbe_exec_chk
(
   input wire logic clk_sys, // Clock.
   input wire logic rstn, // Reset.
   input wire logic opValid, // Offer.
   input wire lsbe_pkg::lsbe_instr_t opIn, // Instruction.
   input wire logic opReady, // Ready.
   input wire logic instrDone, // Done.
   input wire logic nopCycle, // No-op cycle.
   input wire logic discardNext, // Drop.
   input wire logic [lsbe_pkg::DATA_W-1:0] accum_q, // Accumulator.
   input wire logic [lsbe_pkg::PC_W-1:0] pc_q, // Counter.
   input wire lsbe_pkg::lsbe_flags_t flags_q // Flags.
);
   timeunit 1ns;
   timeprecision 1ps;
   import lsbe_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Accepted instruction and its kind.
   wire go = opValid && opReady;
   wire [7:0] k = opIn.op;
   property p_nop; nopCycle |-> instrDone && !opReady; endproperty
   a_nop: assert property (p_nop) else $error("no-op alone");
   property p_drop; discardNext |-> nopCycle; endproperty
   a_drop: assert property (p_drop) else $error("bad drop");
   property p_one;
      go && (k & 8'h1F) != 8'h00 |=> instrDone && !nopCycle;
   endproperty
   a_one: assert property (p_one) else $error("not one cycle");
   property p_jmp;
      go && k[5] |=> !instrDone ##1 nopCycle && $stable(flags_q) &&
         pc_q == $past(pc_q, 2) + 15'h0001 +
         {{6{$past(opIn.lit[8], 2)}}, $past(opIn.lit, 2)};
   endproperty
   a_jmp: assert property (p_jmp)
      else $error("bad branch");
   property p_wjmp;
      go && k[6] |=> !instrDone ##1 nopCycle && $stable(flags_q) &&
         pc_q == $past(pc_q, 2) + 15'h0001 + $past(accum_q, 2);
   endproperty
   a_wjmp: assert property (p_wjmp)
      else $error("bad jump");
   property p_skip;
      go && k[7] |=> (instrDone && !nopCycle ##1
         pc_q == $past(pc_q, 2) + 15'h0001) or (!instrDone ##1
         discardNext && pc_q == $past(pc_q, 2) + 15'h0002);
   endproperty
   a_skip: assert property (p_skip)
      else $error("bad skip");
   property p_lit;
      go && k[0] |=> ##1 accum_q == ($past(accum_q, 2) &
         $past(opIn.lit[7:0], 2)) && flags_q.zero == (accum_q == 8'h00) &&
         flags_q.carry == $past(flags_q.carry, 2);
   endproperty
   a_lit: assert property (p_lit) else $error("bad and");
   property p_bit;
      go && (k[3] || k[4]) |=> ##1 flags_q == $past(flags_q, 2) &&
         accum_q == $past(accum_q, 2);
   endproperty
   a_bit: assert property (p_bit)
      else $error("bit op side");
   // Main scenarios reached.
   c_jmp: cover property (go && k[5]);
   c_drop: cover property (discardNext);
   c_asr: cover property (go && k[2]);
endmodule : lsbe_exec_chk

bind lsbe_exec lsbe_exec_chk chk (.clk_sys(clk_sys), .rstn(rstn),
   .opValid(opValid), .opIn(opIn), .opReady(opReady),
   .instrDone(instrDone), .nopCycle(nopCycle),
   .discardNext(discardNext), .accum_q(accum_q), .pc_q(pc_q),
   .flags_q(flags_q));

`default_nettype wire

// ==== testbench/lsbe_exec_bench.sv ====
`default_nettype none

// Self-checking bench of the execution datapath.
module lsbe_exec_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import lsbe_pkg::*;
   typedef struct packed {
      lsbe_op_t op;
      logic [8:0] lit;
      logic [2:0] bitIdx;
      logic dest;
      logic [7:0] acc, rg, eAcc, eReg;
      logic [1:0] fv;
      logic [14:0] dPc;
   } lsbe_row_t;
   logic clk_sys = 1'b0, rstn = 1'b0, opValid = 1'b0;
   logic accLoadEn = 1'b0, extWrEn = 1'b0;
   lsbe_instr_t opIn = '0;
   logic [7:0] accLoadData = 8'h00, extWrData = 8'h00;
   logic [6:0] extAddr = 7'h00;
   logic opReady, instrDone, nopCycle, discardNext;
   logic [7:0] fileRdData, accum_q;
   logic [14:0] pc_q, ePc = 15'h0000;
   lsbe_flags_t flags_q;
   logic [1:0] eF = 2'h0;
   int failures = 0, comparisons = 0, i;
   // Inputs, then accumulator, register, flags and counter step expected.
   lsbe_row_t rows [16] = '{
      '{OP_AND_LIT, 9'h1F0, 3'h0, 1'h1, 8'h3C, 8'h55, 8'h30, 8'h55, 2'h0, 15'h1},
      '{OP_AND_LIT, 9'h0FF, 3'h0, 1'h0, 8'h00, 8'hAA, 8'h00, 8'hAA, 2'h1, 15'h1},
      '{OP_AND_FILE, 9'h0, 3'h0, 1'h0, 8'hF0, 8'h3C, 8'h30, 8'h3C, 2'h0, 15'h1},
      '{OP_AND_FILE, 9'h0, 3'h0, 1'h1, 8'h0F, 8'hF0, 8'h0F, 8'h00, 2'h1, 15'h1},
      '{OP_ASR, 9'h0, 3'h0, 1'h1, 8'h11, 8'h81, 8'h11, 8'hC0, 2'h2, 15'h1},
      '{OP_ASR, 9'h0, 3'h0, 1'h0, 8'h11, 8'h01, 8'h00, 8'h01, 2'h3, 15'h1},
      '{OP_BIT_CLR, 9'h0, 3'h7, 1'h0, 8'h22, 8'hFF, 8'h22, 8'h7F, 2'h0, 15'h1},
      '{OP_BIT_SET, 9'h0, 3'h0, 1'h1, 8'h22, 8'h00, 8'h22, 8'h01, 2'h0, 15'h1},
      '{OP_REL_JMP, 9'h1FF, 3'h0, 1'h0, 8'h22, 8'h33, 8'h22, 8'h33, 2'h0, 15'h0},
      '{OP_REL_JMP, 9'h100, 3'h0, 1'h0, 8'h22, 8'h33, 8'h22, 8'h33, 2'h0,
         15'h7F01},
      '{OP_REL_JMP, 9'h0FF, 3'h0, 1'h0, 8'h22, 8'h33, 8'h22, 8'h33, 2'h0,
         15'h100},
      '{OP_ACC_JMP, 9'h0, 3'h0, 1'h0, 8'hFF, 8'h33, 8'hFF, 8'h33, 2'h0, 15'h100},
      '{OP_TEST_SKP, 9'h0, 3'h5, 1'h0, 8'h22, 8'h20, 8'h22, 8'h20, 2'h0, 15'h1},
      '{OP_TEST_SKP, 9'h0, 3'h5, 1'h0, 8'h22, 8'hDF, 8'h22, 8'hDF, 2'h0, 15'h2},
      '{OP_ASR, 9'h0, 3'h0, 1'h0, 8'h00, 8'h80, 8'hC0, 8'h80, 2'h0, 15'h1},
      '{OP_BIT_SET, 9'h0, 3'h3, 1'h0, 8'h00, 8'hF7, 8'h00, 8'hFF, 2'h0, 15'h1}};

   lsbe_exec DUT (.clk_sys(clk_sys), .rstn(rstn), .opValid(opValid),
      .opIn(opIn), .opReady(opReady), .instrDone(instrDone),
      .nopCycle(nopCycle), .discardNext(discardNext),
      .accLoadEn(accLoadEn), .accLoadData(accLoadData),
      .extWrEn(extWrEn), .extAddr(extAddr), .extWrData(extWrData),
      .fileRdData(fileRdData), .accum_q(accum_q), .pc_q(pc_q),
      .flags_q(flags_q));

   // Free-running 25 MHz clock.
   initial forever #20 clk_sys = ~clk_sys;

   // Counts a comparison and reports a mismatch.
   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : cmp

   // Prints the verdict and stops.
   task automatic final_report();
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   // Moves to just after the next rising edge.
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask : step

   // Preloads operands, runs one instruction and checks every output.
   task automatic runRow(input lsbe_row_t r, input logic [6:0] a);
      logic two;
      logic [1:0] fm;
      int n;
      two = (r.dPc != 15'h1);
      fm = r.op[2] ? 2'h3 : ((r.op[0] | r.op[1]) ? 2'h1 : 2'h0);
      step();
      accLoadEn = 1'b1;
      accLoadData = r.acc;
      extWrEn = 1'b1;
      extAddr = a;
      extWrData = r.rg;
      step();
      accLoadEn = 1'b0;
      extWrEn = 1'b0;
      opValid = 1'b1;
      opIn = '{r.op, r.lit, a, r.bitIdx, r.dest};
      step();
      opValid = 1'b0;
      n = 1;
      if (instrDone !== 1'b1)
      begin
         step();
         n = 2;
      end
      cmp(n, two ? 2 : 1);
      cmp(nopCycle, two);
      cmp(discardNext, two & r.op[7]);
      step();
      ePc = ePc + r.dPc;
      eF = (eF & ~fm) | (r.fv & fm);
      cmp(accum_q, r.eAcc);
      cmp(flags_q, eF);
      cmp(pc_q, ePc);
      cmp(opReady, 1'b1);
      step();
      cmp(fileRdData, r.eReg);
   endtask : runRow

   // Cuts a hang short well past the expected run time.
   initial
   begin
      #100us;
      failures++;
      final_report();
   end

   // Reset, the table of cases, then a reset in mid-branch.
   initial
   begin
      repeat (4) @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      for (i = 0; i < 16; i++)
         runRow(rows[i], 7'(127 - i));
      step();
      opValid = 1'b1;
      opIn = '{OP_REL_JMP, 9'h005, 7'h00, 3'h0, 1'b0};
      step();
      opValid = 1'b0;
      rstn = 1'b0;
      step();
      step();
      cmp(pc_q, 15'h0000);
      cmp(accum_q, 8'h00);
      cmp(flags_q, 2'h0);
      cmp(opReady, 1'b1);
      cmp(fileRdData, 8'h00);
      rstn = 1'b1;
      step();
      final_report();
   end
endmodule : lsbe_exec_bench

`default_nettype wire
